// File: tb/bndm_data_memory_bench.sv
/* Self-checking bench for the banked nibble data memory.
   Assumes the default product size of sixteen banks. */
module bndm_data_memory_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_in = 1'h0, nrst_in = 1'h0, req_in = 1'h0, cbuf_load_in = 1'h0;
   logic [3:0] op_in = 4'h0, col_in = 4'h0, src_in = 4'h0;
   logic [2:0] row_in = 3'h0;
   logic [15:0] cbuf_data_in = 16'h0, constant_read_buffer_out;
   logic done_out, skip_out;
   logic [3:0] rd_data_out, bank_select_out, window_transfer_out, program_status_word_out;
   logic [15:0] program_address_pointer_out;
   logic [11:0] index_pointer_out;
   logic [7:0] general_register_pointer_out;
   logic [63:0] port_data_out, port_dir_out;
   int error_cnt = 0;
   int compares = 0;
   // Rows: op, row, col, src, read value, flags (bit1 ignore read, bit0 skip)
   logic [23:0] rows [0:44] = '{24'hd12402, 24'hc12040, 24'h012340, 24'hc12070, 24'h212870,
      24'hc120f0, 24'h0121f0, 24'hc7f030, 24'h112000, 24'hc12010, 24'h312210, 24'hc120f0,
      24'h412af0, 24'h5125a0, 24'h6123f0, 24'h712cc1, 24'h712dc0, 24'h812cc1, 24'h812dc0,
      24'h912dc1, 24'ha12cc0, 24'ha123c1, 24'he128c1, 24'he123c0, 24'hf123c1, 24'hf128c0,
      24'hb12dc0, 24'hc120d0, 24'hd70300, 24'hd0c800, 24'hd79500, 24'hd12902, 24'hd7a600,
      24'hd79050, 24'hc7a060, 24'hc120d0, 24'hd79f00, 24'hd05700, 24'hc05000, 24'hd6aa00,
      24'hc6a0a0, 24'hd74100, 24'hd77400, 24'hd78500, 24'hd7e900};
   bndm_data_memory dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .req_in(req_in),
      .op_in(op_in), .row_in(row_in), .col_in(col_in), .src_in(src_in),
      .cbuf_load_in(cbuf_load_in), .cbuf_data_in(cbuf_data_in), .done_out(done_out),
      .rd_data_out(rd_data_out), .skip_out(skip_out),
      .program_address_pointer_out(program_address_pointer_out),
      .window_transfer_out(window_transfer_out), .bank_select_out(bank_select_out),
      .index_pointer_out(index_pointer_out),
      .general_register_pointer_out(general_register_pointer_out),
      .program_status_word_out(program_status_word_out),
      .port_data_out(port_data_out), .port_dir_out(port_dir_out),
      .constant_read_buffer_out(constant_read_buffer_out));
   // Clock at 250 MHz
   always #2 core_clk_in = ~core_clk_in;
   task chk(input logic [63:0] got, input logic [63:0] exp);
      compares += 1;
      if (got !== exp)
      begin
         error_cnt += 1;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task conclude;
      if (error_cnt == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // One instruction, answer checked the cycle after it is taken
   task step(input logic [23:0] r);
      @(posedge core_clk_in);
      req_in <= 1'h1;
      {op_in, row_in, col_in, src_in} <= {r[23:20], r[18:16], r[15:12], r[11:8]};
      @(posedge core_clk_in);
      req_in <= 1'h0;
      #1;
      chk(done_out, 64'h1);
      if (!r[1])
         chk(rd_data_out, r[7:4]);
      chk(skip_out, r[0]);
   endtask
   initial
   begin
      repeat (6) @(posedge core_clk_in);
      chk({done_out, rd_data_out, skip_out, bank_select_out, constant_read_buffer_out}, 64'h0);
      chk(port_data_out | port_dir_out, 64'h0);
      nrst_in <= 1'h1;
      foreach (rows[i]) step(rows[i]);
      chk(bank_select_out, 64'hf);
      chk(port_data_out[3:0], 64'h3);
      chk(port_dir_out[43:40], 64'ha);
      chk(constant_read_buffer_out[3:0], 64'h8);
      chk({program_address_pointer_out, window_transfer_out, index_pointer_out}, 64'h10045600);
      chk(general_register_pointer_out, 64'h9);
      chk(program_status_word_out, 64'h2);
      @(posedge core_clk_in);
      cbuf_load_in <= 1'h1;
      cbuf_data_in <= 16'h1234;
      @(posedge core_clk_in);
      cbuf_load_in <= 1'h0;
      #1;
      chk(constant_read_buffer_out, 64'h1234);
      // Mid-run reset clears the mapped nibbles at once
      @(posedge core_clk_in);
      nrst_in <= 1'h0;
      #1;
      chk({bank_select_out, constant_read_buffer_out, program_address_pointer_out}, 64'h0);
      @(posedge core_clk_in);
      nrst_in <= 1'h1;
      step(24'hc7f000);
      conclude;
   end
   // Watchdog against a hang
   initial
   begin
      #100000;
      error_cnt += 1;
      conclude;
   end
endmodule

// File: tb/bndm_data_memory_chk.sv
/* Checker for the banked nibble data memory top ports.
   Assumes one clock and an active-low asynchronous reset. */
module bndm_data_memory_chk
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic nrst_in,
   // Access side
   input wire logic req_in,
   input wire logic [3:0] op_in,
   input wire logic [2:0] row_in,
   input wire logic [3:0] col_in,
   input wire logic [3:0] src_in,
   input wire logic cbuf_load_in,
   input wire logic [15:0] cbuf_data_in,
   // Answers and mapped nibbles
   input wire logic done_out,
   input wire logic skip_out,
   input wire logic [3:0] bank_select_out,
   input wire logic [63:0] port_data_out,
   input wire logic [63:0] port_dir_out,
   input wire logic [15:0] constant_read_buffer_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!nrst_in);
   // Answer timing
   done_pulse_a: assert property (req_in |=> done_out) else $error("no done");
   done_quiet_a: assert property (!req_in |=> !done_out && !skip_out)
      else $error("stray done");
   // Mapped writes
   bank_write_a: assert property (req_in && op_in == 4'hd && {row_in, col_in} == 7'h79
      |=> bank_select_out == $past(src_in)) else $error("bank select");
   port_write_a: assert property (req_in && op_in == 4'hd && bank_select_out == 4'h0
      && {row_in, col_in} == 7'h70 |=> port_data_out[3:0] == $past(src_in)) else $error("port");
   dir_write_a: assert property (req_in && op_in == 4'hd && bank_select_out == 4'hf
      && row_in == 3'h6 |=> 4'(port_dir_out >> {$past(col_in), 2'h0}) == $past(src_in))
      else $error("dir");
   absent_write_a: assert property (req_in && bank_select_out == 4'hf && row_in < 3'h6
      |=> $stable(port_dir_out) && $stable(port_data_out) && $stable(bank_select_out))
      else $error("absent write");
   cbuf_load_a: assert property (cbuf_load_in && !req_in
      |=> constant_read_buffer_out == $past(cbuf_data_in)) else $error("cbuf load");
   idle_hold_a: assert property (!req_in && !cbuf_load_in |=> $stable(port_data_out)
      && $stable(constant_read_buffer_out) && $stable(bank_select_out)) else $error("idle");
endmodule

bind bndm_data_memory bndm_data_memory_chk chk (.*);

// File: verilog/bndm_data_memory.sv
/*
 * Banked 4-bit data memory: general storage, shared control nibbles, port
 * data and direction select nibbles and the constant-read buffer, accessed
 * one nibble per accepted memory instruction.
 * Assumes the CPU presents one request per cycle at most and that the
 * constant buffer load comes from the table reference logic.
 */
import bndm_pkg::*;

// Operation
// - Bank holds 128 nibbles, eight by sixteen
// - Row and column come from operand
// - Bank comes from bank select register
// - Each instruction addresses exactly one nibble; add and subtract also write carry and zero in the status word unless it is the addressed nibble
// - 74H-7FH shared control nibbles in all banks
// - Control nibbles read and written like memory
// - Bank zero 0CH-0FH is constant buffer
// - Banks 0-3 70H-73H are port data
// - Top bank 60H-6FH are direction selects
// - Top bank 00H-5FH has no storage
// - Remaining implemented locations are general storage
// - General capacity follows product bank count
// - Reads of absent storage return filler
// - Writes to absent storage change nothing but carry and zero, which add and subtract still set
// - General storage not cleared at reset
// - Full arithmetic, compare, transfer, test set
// - Direction selects exist in every product size
module bndm_data_memory
   import bndm_pkg::*;
#(
   parameter int NUM_BANKS = 16
)
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic nrst_in,
   // Instruction access
   input wire logic req_in,
   input wire logic [3:0] op_in,
   input wire logic [2:0] row_in,
   input wire logic [3:0] col_in,
   input wire logic [3:0] src_in,
   // Constant buffer load
   input wire logic cbuf_load_in,
   input wire logic [15:0] cbuf_data_in,
   // Instruction answer
   output logic done_out,
   output logic [3:0] rd_data_out,
   output logic skip_out,
   // Control nibbles seen by the CPU
   output logic [15:0] program_address_pointer_out,
   output logic [3:0] window_transfer_out,
   output logic [3:0] bank_select_out,
   output logic [11:0] index_pointer_out,
   output logic [7:0] general_register_pointer_out,
   output logic [3:0] program_status_word_out,
   // Peripheral nibbles
   output logic [63:0] port_data_out,
   output logic [63:0] port_dir_out,
   output logic [15:0] constant_read_buffer_out
);

   // ----------------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------------
   // Product sizes: 16, 10 or 6 general banks
   if (NUM_BANKS != 16 && NUM_BANKS != 10 && NUM_BANKS != 6)
   begin : g_bad_banks
      $error("NUM_BANKS must be 6, 10 or 16");
   end

   localparam int SYS_BANK_IDX = int'(BNDM_OFS_BANK_SELECT - BNDM_SYS_FIRST);
   localparam int SYS_PSW_IDX = int'(BNDM_OFS_PROGRAM_STATUS_WORD - BNDM_SYS_FIRST);
   localparam int SYS_AR_IDX = int'(BNDM_OFS_PROGRAM_ADDRESS_POINTER - BNDM_SYS_FIRST);
   localparam int SYS_WR_IDX = int'(BNDM_OFS_WINDOW_TRANSFER - BNDM_SYS_FIRST);
   localparam int SYS_IX_IDX = int'(BNDM_OFS_INDEX_POINTER - BNDM_SYS_FIRST);
   localparam int SYS_RP_IDX = int'(BNDM_OFS_GENERAL_REGISTER_POINTER - BNDM_SYS_FIRST);
   localparam int GP_DEPTH = NUM_BANKS * BNDM_LOCS;

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   logic [3:0] gp_mem [0:GP_DEPTH-1];       // General storage, no reset
   logic [3:0] sys_nib [0:BNDM_SYS_COUNT-1]; // Shared control nibbles
   logic [3:0] port_nib [0:15];             // Port data nibbles
   logic [3:0] dir_nib [0:15];              // Direction select nibbles
   logic [3:0] cbuf_nib [0:3];              // Constant buffer nibbles
   logic [3:0] next_sys_nib [0:BNDM_SYS_COUNT-1];
   logic [3:0] next_port_nib [0:15];
   logic [3:0] next_dir_nib [0:15];
   logic [3:0] next_cbuf_nib [0:3];

   // Answer registers
   logic next_done;
   logic [3:0] next_rd_data;
   logic next_skip;

   // Access datapath
   bndm_op_if opb ();                       // Carrier to decoder and ALU
   logic [10:0] gp_addr;                    // Flat general storage index
   logic [3:0] rd_val;                      // Nibble at the addressed location
   logic gp_we;                             // General storage write
   logic store;                             // Location is written this cycle

   // ----------------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------------
   bndm_map_decode #(
      .NUM_BANKS(NUM_BANKS)
   ) u_decode (
      .bus(opb)
   );

   bndm_nibble_alu u_alu (
      .bus(opb)
   );

   // ----------------------------------------------------------------------
   // Address formation
   // ----------------------------------------------------------------------
   assign opb.bank = sys_nib[SYS_BANK_IDX];
   assign opb.row = row_in;
   assign opb.col = col_in;
   assign opb.op = bndm_op_type'(op_in);
   assign opb.src = src_in;
   assign opb.carry_in = sys_nib[SYS_PSW_IDX][BNDM_PSW_CY_BIT];
   assign opb.mem_val = rd_val;
   // Bank-major flat index: 128 nibbles per bank
   assign gp_addr = {opb.bank[3:0], row_in, col_in};
   assign store = req_in && opb.writes;

   // ----------------------------------------------------------------------
   // Read multiplexer: one nibble per instruction
   // ----------------------------------------------------------------------
   always_comb
   begin
      rd_val = BNDM_ABSENT_READ;
      case (opb.region)
         BNDM_REG_GP: rd_val = gp_mem[gp_addr];
         BNDM_REG_SYS: rd_val = sys_nib[opb.sub_idx];
         BNDM_REG_PORT: rd_val = port_nib[opb.sub_idx];
         BNDM_REG_DIR: rd_val = dir_nib[opb.sub_idx];
         BNDM_REG_CBUF: rd_val = cbuf_nib[opb.sub_idx[1:0]];
         BNDM_REG_NONE: rd_val = BNDM_ABSENT_READ;
         default: rd_val = BNDM_ABSENT_READ;
      endcase
   end

   // ----------------------------------------------------------------------
   // General storage: write only, never reset
   // ----------------------------------------------------------------------
   assign gp_we = store && (opb.region == BNDM_REG_GP);

   always_ff @(posedge core_clk_in)
   begin
      // No reset branch: contents are undefined after power-on
      if (gp_we)
      begin
         gp_mem[gp_addr] <= opb.result;
      end
   end

   // ----------------------------------------------------------------------
   // Control nibbles next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      next_sys_nib = sys_nib;
      // Arithmetic flags go to the status word first
      if (req_in && opb.flags)
      begin
         next_sys_nib[SYS_PSW_IDX][BNDM_PSW_CY_BIT] = opb.carry_out;
         next_sys_nib[SYS_PSW_IDX][BNDM_PSW_Z_BIT] = (opb.result == 4'h0);
      end
      // An explicit write of the addressed nibble wins over flag update
      if (store && opb.region == BNDM_REG_SYS)
      begin
         next_sys_nib[opb.sub_idx] = opb.result;
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         for (int i = 0; i < BNDM_SYS_COUNT; i++)
         begin
            sys_nib[i] <= BNDM_SYS_RESET;
         end
      end
      else
      begin
         sys_nib <= next_sys_nib;
      end
   end

   // ----------------------------------------------------------------------
   // Peripheral nibbles next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      next_port_nib = port_nib;
      next_dir_nib = dir_nib;
      next_cbuf_nib = cbuf_nib;
      // Table read load of the whole buffer
      if (cbuf_load_in)
      begin
         for (int i = 0; i < 4; i++)
         begin
            next_cbuf_nib[i] = cbuf_data_in[4*i +: 4];
         end
      end
      // Instruction writes; absent storage falls through unchanged
      if (store)
      begin
         case (opb.region)
            BNDM_REG_PORT: next_port_nib[opb.sub_idx] = opb.result;
            BNDM_REG_DIR: next_dir_nib[opb.sub_idx] = opb.result;
            BNDM_REG_CBUF: next_cbuf_nib[opb.sub_idx[1:0]] = opb.result;
            default: next_port_nib = port_nib;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         for (int i = 0; i < 16; i++)
         begin
            port_nib[i] <= BNDM_SYS_RESET;
            dir_nib[i] <= BNDM_SYS_RESET;
         end
         for (int i = 0; i < 4; i++)
         begin
            cbuf_nib[i] <= BNDM_SYS_RESET;
         end
      end
      else
      begin
         port_nib <= next_port_nib;
         dir_nib <= next_dir_nib;
         cbuf_nib <= next_cbuf_nib;
      end
   end

   // ----------------------------------------------------------------------
   // Answer next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      next_done = req_in;
      next_rd_data = rd_data_out;
      next_skip = 1'b0;
      // Value read before any write of this instruction
      if (req_in)
      begin
         next_rd_data = rd_val;
         next_skip = opb.skip;
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         done_out <= 1'b0;
         rd_data_out <= BNDM_ABSENT_READ;
         skip_out <= 1'b0;
      end
      else
      begin
         done_out <= next_done;
         rd_data_out <= next_rd_data;
         skip_out <= next_skip;
      end
   end

   // ----------------------------------------------------------------------
   // Flop-driven views of the nibbles (generate loops for multi-nibble views, plain assigns for single nibbles)
   // ----------------------------------------------------------------------
   for (genvar g = 0; g < 16; g++)
   begin : g_nib
      assign port_data_out[4*g +: 4] = port_nib[g];
      assign port_dir_out[4*g +: 4] = dir_nib[g];
   end

   for (genvar g = 0; g < 4; g++)
   begin : g_cbuf
      assign constant_read_buffer_out[4*g +: 4] = cbuf_nib[g];
      // Most significant nibble sits at the lowest address
      assign program_address_pointer_out[4*(3-g) +: 4] = sys_nib[SYS_AR_IDX + g];
   end

   for (genvar g = 0; g < 3; g++)
   begin : g_ix
      assign index_pointer_out[4*(2-g) +: 4] = sys_nib[SYS_IX_IDX + g];
   end

   for (genvar g = 0; g < 2; g++)
   begin : g_rp
      assign general_register_pointer_out[4*(1-g) +: 4] = sys_nib[SYS_RP_IDX + g];
   end

   assign window_transfer_out = sys_nib[SYS_WR_IDX];
   assign bank_select_out = sys_nib[SYS_BANK_IDX];
   assign program_status_word_out = sys_nib[SYS_PSW_IDX];

endmodule

// File: verilog/bndm_map_decode.sv
/*
 * Address decoder of the banked data memory: classifies bank:row:col into a
 * storage class and an index. Purely combinational; NUM_BANKS is the number
 * of implemented general banks (the top bank is always present).
 */
module bndm_map_decode
   import bndm_pkg::*;
#(
   parameter int NUM_BANKS = 16
)
(
   // Carrier
   bndm_op_if.dec bus
);

   logic [6:0] addr;      // In-bank address
   logic bank_impl;       // Bank has general storage

   assign addr = {bus.row, bus.col};
   assign bank_impl = (int'(bus.bank) < NUM_BANKS);

   // ----------------------------------------------------------------------
   // Region classification
   // ----------------------------------------------------------------------
   always_comb
   begin
      bus.region = BNDM_REG_NONE;
      bus.sub_idx = addr[3:0];
      if (addr >= BNDM_SYS_FIRST)
      begin
         // Same control nibbles in every bank, implemented or not
         bus.region = BNDM_REG_SYS;
         bus.sub_idx = 4'(addr - BNDM_SYS_FIRST);
      end
      else if (bus.bank == BNDM_TOP_BANK && addr >= BNDM_DIR_FIRST
               && addr <= BNDM_DIR_LAST)
      begin
         // Direction selects present in every product size
         bus.region = BNDM_REG_DIR;
         bus.sub_idx = 4'(addr - BNDM_DIR_FIRST);
      end
      else if (bus.bank == BNDM_TOP_BANK && addr <= BNDM_ABSENT_LAST)
      begin
         // Empty lower area of the top bank
         bus.region = BNDM_REG_NONE;
      end
      else if (!bank_impl)
      begin
         // Bank missing in this product size
         bus.region = BNDM_REG_NONE;
      end
      else if (addr >= BNDM_PORT_FIRST && addr <= BNDM_PORT_LAST)
      begin
         // Port data nibbles in the low banks; nothing behind them elsewhere,
         // so general banks below the top bank keep 112 nibbles of general storage, except bank 0, which keeps 108
         if (bus.bank <= BNDM_PORT_BANK_LAST)
         begin
            bus.region = BNDM_REG_PORT;
            bus.sub_idx = {bus.bank[1:0], 2'(addr - BNDM_PORT_FIRST)};
         end
         else
         begin
            bus.region = BNDM_REG_NONE;
         end
      end
      else if (bus.bank == BNDM_CBUF_BANK && addr >= BNDM_CBUF_FIRST
               && addr <= BNDM_CBUF_LAST)
      begin
         // Constant-read buffer nibbles
         bus.region = BNDM_REG_CBUF;
         bus.sub_idx = 4'(addr - BNDM_CBUF_FIRST);
      end
      else
      begin
         // Everything else is general storage
         bus.region = BNDM_REG_GP;
      end
   end

endmodule

// File: verilog/bndm_nibble_alu.sv
/*
 * Nibble ALU of the data memory instruction group: computes the write-back
 * nibble, new carry and skip condition from the location and second operand.
 * Purely combinational; the core decides whether the result is stored.
 */
module bndm_nibble_alu
   import bndm_pkg::*;
(
   // Carrier
   bndm_op_if.alu bus
);

   logic [4:0] sum;       // Sum with carry out
   logic [4:0] diff;      // Difference with borrow out

   // ----------------------------------------------------------------------
   // Operation select
   // ----------------------------------------------------------------------
   always_comb
   begin
      sum = 5'h00;
      diff = 5'h00;
      bus.result = bus.mem_val;
      bus.carry_out = bus.carry_in;
      bus.skip = 1'b0;
      bus.writes = 1'b0;
      bus.flags = 1'b0;
      case (bus.op)
         BNDM_OP_ADD, BNDM_OP_ADD_WITH_CARRY:
         begin
            // Add, optionally chained through the carry
            sum = 5'(bus.mem_val) + 5'(bus.src)
                  + ((bus.op == BNDM_OP_ADD_WITH_CARRY) ? 5'(bus.carry_in) : 5'h00);
            bus.result = sum[3:0];
            bus.carry_out = sum[4];
            bus.writes = 1'b1;
            bus.flags = 1'b1;
         end
         BNDM_OP_SUB, BNDM_OP_SUBTRACT_WITH_BORROW:
         begin
            // Subtract, optionally chained through the borrow
            diff = 5'(bus.mem_val) - 5'(bus.src)
                   - ((bus.op == BNDM_OP_SUBTRACT_WITH_BORROW) ? 5'(bus.carry_in) : 5'h00);
            bus.result = diff[3:0];
            bus.carry_out = diff[4];
            bus.writes = 1'b1;
            bus.flags = 1'b1;
         end
         BNDM_OP_AND:
         begin
            bus.result = bus.mem_val & bus.src;
            bus.writes = 1'b1;
         end
         BNDM_OP_OR:
         begin
            bus.result = bus.mem_val | bus.src;
            bus.writes = 1'b1;
         end
         BNDM_OP_XOR:
         begin
            bus.result = bus.mem_val ^ bus.src;
            bus.writes = 1'b1;
         end
         // Compare forms leave memory untouched
         BNDM_OP_SKIP_ON_EQUAL: bus.skip = (bus.mem_val == bus.src);
         BNDM_OP_SKIP_ON_GREATER_OR_EQUAL: bus.skip = (bus.mem_val >= bus.src);
         BNDM_OP_SKIP_ON_LESS: bus.skip = (bus.mem_val < bus.src);
         BNDM_OP_SKIP_ON_NOT_EQUAL: bus.skip = (bus.mem_val != bus.src);
         BNDM_OP_INDIRECT_TRANSFER, BNDM_OP_MEMORY_WRITE_OP:
         begin
            // Transfer into the location
            bus.result = bus.src;
            bus.writes = 1'b1;
         end
         BNDM_OP_MEMORY_READ_OP: bus.result = bus.mem_val;
         // Bit tests: src is the mask
         BNDM_OP_SKIP_IF_BITS_TRUE: bus.skip = ((bus.mem_val & bus.src) == bus.src);
         BNDM_OP_SKIP_IF_BITS_FALSE: bus.skip = ((bus.mem_val & bus.src) == 4'h0);
         default: bus.result = bus.mem_val;
      endcase
   end

endmodule

// File: verilog/bndm_op_if.sv
/*
 * Carrier between the data memory core, its address decoder and its nibble ALU.
 * Assumes all three sit in the same clock domain; it carries no state.
 */
interface bndm_op_if;
   import bndm_pkg::*;

   // Address side
   logic [3:0] bank;              // Bank taken from bank select
   logic [2:0] row;               // Row from the operand
   logic [3:0] col;               // Column from the operand
   bndm_region_type region;       // Storage class found
   logic [3:0] sub_idx;           // Index within that storage class

   // Operation side
   bndm_op_type op;               // Instruction
   logic [3:0] mem_val;           // Nibble read from the location
   logic [3:0] src;               // Second operand
   logic carry_in;                // Carry from the status word
   logic [3:0] result;            // Nibble to write back
   logic carry_out;               // New carry
   logic skip;                    // Skip condition met
   logic writes;                  // Instruction writes the location
   logic flags;                   // Instruction updates carry and zero

   modport dec (input bank, row, col, output region, sub_idx);
   modport alu (input op, mem_val, src, carry_in,
                output result, carry_out, skip, writes, flags);
   modport core (output bank, row, col, op, mem_val, src, carry_in,
                 input region, sub_idx, result, carry_out, skip, writes, flags);
endinterface

// File: verilog/bndm_pkg.sv
/*
 * Shared constants and types of the banked nibble data memory: address map,
 * system register offsets, status word bits, access operations and regions.
 * Assumes a single CPU clock and one memory instruction per accepted request.
 */
package bndm_pkg;

   // ----------------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------------
   localparam int BNDM_ROWS = 8;             // Rows per bank
   localparam int BNDM_COLS = 16;            // Columns per bank
   localparam int BNDM_LOCS = BNDM_ROWS * BNDM_COLS;  // Nibbles per bank
   localparam int BNDM_MAX_BANKS = 16;       // Bank select reaches sixteen banks
   localparam int BNDM_SYS_COUNT = 12;       // Shared control nibbles

   // ----------------------------------------------------------------------
   // Address map (7-bit in-bank address = row:col)
   // ----------------------------------------------------------------------
   localparam logic [6:0] BNDM_SYS_FIRST = 7'h74;     // Shared control area start
   localparam logic [6:0] BNDM_PORT_FIRST = 7'h70;    // Port data area start
   localparam logic [6:0] BNDM_PORT_LAST = 7'h73;     // Port data area end
   localparam logic [6:0] BNDM_DIR_FIRST = 7'h60;     // Direction select start
   localparam logic [6:0] BNDM_DIR_LAST = 7'h6f;      // Direction select end
   localparam logic [6:0] BNDM_ABSENT_LAST = 7'h5f;   // Empty area end in top bank
   localparam logic [6:0] BNDM_CBUF_FIRST = 7'h0c;    // Constant buffer start
   localparam logic [6:0] BNDM_CBUF_LAST = 7'h0f;     // Constant buffer end
   localparam logic [3:0] BNDM_TOP_BANK = 4'hf;       // Bank holding direction selects
   localparam logic [3:0] BNDM_PORT_BANK_LAST = 4'h3; // Last bank with port data
   localparam logic [3:0] BNDM_CBUF_BANK = 4'h0;      // Bank holding constant buffer

   // ----------------------------------------------------------------------
   // Shared control nibble offsets (index = address minus area start)
   // ----------------------------------------------------------------------
   localparam logic [6:0] BNDM_OFS_PROGRAM_ADDRESS_POINTER = 7'h74;
   localparam logic [6:0] BNDM_OFS_WINDOW_TRANSFER = 7'h78;
   localparam logic [6:0] BNDM_OFS_BANK_SELECT = 7'h79;
   localparam logic [6:0] BNDM_OFS_INDEX_POINTER = 7'h7a;
   localparam logic [6:0] BNDM_OFS_GENERAL_REGISTER_POINTER = 7'h7d;
   localparam logic [6:0] BNDM_OFS_PROGRAM_STATUS_WORD = 7'h7f;
   localparam logic [3:0] BNDM_SYS_RESET = 4'h0;      // Reset value of each control nibble

   // ----------------------------------------------------------------------
   // Status word bits and read value of absent storage
   // ----------------------------------------------------------------------
   localparam int BNDM_PSW_CY_BIT = 1;       // Carry / borrow
   localparam int BNDM_PSW_Z_BIT = 0;        // Zero result
   localparam logic [3:0] BNDM_ABSENT_READ = 4'h0;    // Value returned from absent storage

   // ----------------------------------------------------------------------
   // Memory instruction group
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      BNDM_OP_ADD = 4'h0,
      BNDM_OP_ADD_WITH_CARRY = 4'h1,
      BNDM_OP_SUB = 4'h2,
      BNDM_OP_SUBTRACT_WITH_BORROW = 4'h3,
      BNDM_OP_AND = 4'h4,
      BNDM_OP_OR = 4'h5,
      BNDM_OP_XOR = 4'h6,
      BNDM_OP_SKIP_ON_EQUAL = 4'h7,
      BNDM_OP_SKIP_ON_GREATER_OR_EQUAL = 4'h8,
      BNDM_OP_SKIP_ON_LESS = 4'h9,
      BNDM_OP_SKIP_ON_NOT_EQUAL = 4'ha,
      BNDM_OP_INDIRECT_TRANSFER = 4'hb,
      BNDM_OP_MEMORY_READ_OP = 4'hc,
      BNDM_OP_MEMORY_WRITE_OP = 4'hd,
      BNDM_OP_SKIP_IF_BITS_TRUE = 4'he,
      BNDM_OP_SKIP_IF_BITS_FALSE = 4'hf
   } bndm_op_type;

   // Storage class behind an address
   typedef enum logic [2:0] {
      BNDM_REG_NONE = 3'h0,
      BNDM_REG_GP = 3'h1,
      BNDM_REG_SYS = 3'h2,
      BNDM_REG_PORT = 3'h3,
      BNDM_REG_DIR = 3'h4,
      BNDM_REG_CBUF = 3'h5
   } bndm_region_type;

endpackage
